// ---- verilog/cfs_sync.v ----
`include "cfs_map.vh"
`default_nettype none
module cfs_sync #(
    parameter IS_TX = 0,
    parameter SMP_W = 12,
    parameter CNT_W = 32,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire enable_i,
    input wire [1:0] start_sel_i,
    input wire [1:0] stop_sel_i,
    input wire [CNT_W-1:0] sample_count_i,
    input wire sw_trig_i,
    input wire hw_trig_i,
    input wire dma_busy_i,
    output reg dma_arm_o,
    output reg [6:0] state_o,
    output reg idle_o,
    output reg proc_o,
    output reg rx_overrun_o,
    input wire [`CFS_PAY_W-1:0] tx_rd_data_i,
    input wire tx_rd_valid_i,
    output wire tx_rd_ready_o,
    input wire tx_strobe_i,
    output reg [SMP_W-1:0] tx_item_o,
    output reg tx_item_valid_o,
    input wire rx_strobe_i,
    input wire [SMP_W-1:0] rx_item_i,
    output wire [`CFS_PAY_W-1:0] rx_wr_data_o,
    output wire rx_wr_valid_o,
    input wire rx_wr_ready_i
);
    localparam [6:0] ST_IDLE = `CFS_ST_IDLE;
    localparam [6:0] ST_INIT = `CFS_ST_INIT;
    localparam [6:0] ST_PRIME = `CFS_ST_PRIME;
    localparam [6:0] ST_START = `CFS_ST_START;
    localparam [6:0] ST_STOP = `CFS_ST_STOP;
    localparam [6:0] ST_PURGE = `CFS_ST_PURGE;
    localparam [6:0] ST_RESID = `CFS_ST_RESID;
    localparam [`CFS_TMR_W-1:0] INIT_CYC = `CFS_INIT_CYC;
    localparam [`CFS_TMR_W-1:0] PURGE_CYC = `CFS_PURGE_CYC;
    localparam IW = `CFS_ITEM_W;

    // Item helpers: sign extension for receive, lane selection for transmit

    function [IW-1:0] sext16;
        input [SMP_W-1:0] v;
        begin
            sext16 = {{(IW-SMP_W){v[SMP_W-1]}}, v};
        end
    endfunction

    function [IW-1:0] lane_item;
        input [`CFS_PAY_W-1:0] w;
        input [1:0] lane;
        begin
            lane_item = w[lane*IW +: IW];
        end
    endfunction

    reg [6:0] state_q;
    reg [6:0] state_d;
    reg [`CFS_TMR_W-1:0] tmr_q;
    reg [CNT_W-1:0] smp_cnt_q;
    reg sw_prev_q;
    reg hw_s1_q;
    reg hw_s2_q;
    reg hw_s3_q;
    reg hw_lvl_q;
    reg [1:0] lane_q;
    reg [`CFS_PAY_W-IW-1:0] pack_q;
    reg [`CFS_PAY_W-1:0] word_q;
    reg word_vld_q;

    // FIFO side of the datapath

    wire fifo_in_ready;
    wire [`CFS_PAY_W-1:0] fifo_out_data;
    wire fifo_out_valid;
    wire fifo_empty;


    // Software trigger is same-clock logic; the hardware pin is synchronised first
    wire sw_rise = sw_trig_i & ~sw_prev_q;
    wire hw_stable = (hw_s2_q == hw_s3_q);
    wire hw_rise = hw_stable & hw_s3_q & ~hw_lvl_q;

    wire start_ev = (start_sel_i == `CFS_START_NONE) |
                    ((start_sel_i == `CFS_START_SW) & sw_rise) |
                    ((start_sel_i == `CFS_START_HW) & hw_rise);
    wire cnt_mode = (stop_sel_i == `CFS_STOP_CNT);
    wire cnt_done = (smp_cnt_q == sample_count_i);
    wire stop_ev = ~enable_i |
                   ((stop_sel_i == `CFS_STOP_SW) & sw_rise) |
                   ((stop_sel_i == `CFS_STOP_HW) & hw_rise) |
                   (cnt_mode & cnt_done);
    // Throttle closes the gate as soon as the programmed count is reached
    wire gate_open = (state_q == ST_STOP) & ~(cnt_mode & cnt_done);

    wire tx_take = (IS_TX != 0) & tx_strobe_i & gate_open & fifo_out_valid;
    wire tx_pop = tx_take & (lane_q == `CFS_LAST_LANE);

    // Selected 16-bit lane of the head payload; low lane goes out first
    wire [IW-1:0] tx_lane = lane_item(fifo_out_data, lane_q);

    wire rx_take = (IS_TX == 0) & rx_strobe_i & gate_open;
    wire rx_word = rx_take & (lane_q == `CFS_LAST_LANE);
    wire fifo_push_rx = word_vld_q & fifo_in_ready;

    wire [`CFS_PAY_W-1:0] fifo_in_data = (IS_TX != 0) ? tx_rd_data_i : word_q;
    wire fifo_in_valid = (IS_TX != 0) ? tx_rd_valid_i : word_vld_q;
    // Transmit side only accepts host data while armed; idle requests are ignored
    wire fifo_accept = (IS_TX != 0) ? dma_arm_o : 1'b1;
    wire fifo_out_ready = (IS_TX != 0) ? tx_pop : rx_wr_ready_i;

    assign tx_rd_ready_o = (IS_TX != 0) & fifo_in_ready;
    assign rx_wr_data_o = fifo_out_data;
    assign rx_wr_valid_o = (IS_TX == 0) & fifo_out_valid;

    // One FIFO serves either direction; idle flushes it so a new run starts clean

    cfs_fifo #(
        .WIDTH(`CFS_PAY_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_i(mclk_i),
        .resetn_i(resetn_i),
        .flush_i(state_q == ST_IDLE),
        .accept_en_i(fifo_accept),
        .in_data_i(fifo_in_data),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .empty_o(fifo_empty)
    );


    // Sequencer next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (enable_i) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                if (!enable_i) begin
                    state_d = ST_IDLE;
                end else if (tmr_q >= INIT_CYC - 8'h01) begin
                    // Timer starts at zero on entry, so the last dwell cycle is INIT_CYC-1
                    state_d = (IS_TX != 0) ? ST_PRIME : ST_START;
                end
            end
            ST_PRIME: begin
                if (!enable_i) begin
                    state_d = ST_RESID;
                end else if (!fifo_in_ready && fifo_out_valid) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                if (!enable_i) begin
                    state_d = ST_RESID;
                end else if (start_ev) begin
                    state_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (stop_ev) begin
                    state_d = (IS_TX != 0) ? ST_RESID : ST_PURGE;
                end
            end
            ST_PURGE: begin
                if (tmr_q >= PURGE_CYC && !word_vld_q) begin
                    state_d = ST_RESID;
                end
            end
            ST_RESID: begin
                if (IS_TX != 0) begin
                    if (!dma_busy_i) begin
                        state_d = ST_IDLE;
                    end
                end else if (fifo_empty && !word_vld_q && !dma_busy_i) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            tmr_q <= {`CFS_TMR_W{1'b0}};
            state_o <= ST_IDLE;
            idle_o <= 1'b1;
            proc_o <= 1'b0;
            dma_arm_o <= 1'b0;
        end else begin
            state_q <= state_d;
            state_o <= state_d;
            idle_o <= (state_d == ST_IDLE);
            proc_o <= (state_d == ST_STOP);
            if (state_d != state_q) begin
                tmr_q <= {`CFS_TMR_W{1'b0}};
            end else if (tmr_q != {`CFS_TMR_W{1'b1}}) begin
                tmr_q <= tmr_q + {{(`CFS_TMR_W-1){1'b0}}, 1'b1};
            end
            // Transmit residue keeps DMA off so a late burst cannot start
            case (state_d)
                ST_PRIME, ST_START, ST_STOP, ST_PURGE: begin
                    dma_arm_o <= 1'b1;
                end
                ST_RESID: begin
                    dma_arm_o <= (IS_TX == 0);
                end
                default: begin
                    dma_arm_o <= 1'b0;
                end
            endcase
        end
    end


    // Trigger edge detection
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sw_prev_q <= 1'b0;
            hw_s1_q <= 1'b0;
            hw_s2_q <= 1'b0;
            hw_s3_q <= 1'b0;
            hw_lvl_q <= 1'b0;
        end else begin
            sw_prev_q <= sw_trig_i;
            hw_s1_q <= hw_trig_i;
            hw_s2_q <= hw_s1_q;
            hw_s3_q <= hw_s2_q;
            if (hw_stable) begin
                hw_lvl_q <= hw_s3_q;
            end
        end
    end


    // Sample counter and lane position, shared by both directions
    // The count clears to zero outside the stop-wait state, so the throttle and the stop agree
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            smp_cnt_q <= {CNT_W{1'b0}};
            lane_q <= 2'h0;
        end else if (state_q != ST_STOP) begin
            smp_cnt_q <= {CNT_W{1'b0}};
            // Receive lanes restart with each run; partial words are dropped
            if (IS_TX == 0 || state_q == ST_IDLE) begin
                lane_q <= 2'h0;
            end
        end else if (tx_take || rx_take) begin
            smp_cnt_q <= smp_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            lane_q <= lane_q + 2'h1;
        end
    end


    // Transmit gate: one item per strobe, zero when closed or starved
    // The channel never stalls, so a starved FIFO also yields zeros
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_item_o <= {SMP_W{1'b0}};
            tx_item_valid_o <= 1'b0;
        end else begin
            tx_item_valid_o <= (IS_TX != 0) & tx_strobe_i;
            if (tx_strobe_i) begin
                if (tx_take) begin
                    // Upper lane bits are dropped when the channel is narrower than 16
                    tx_item_o <= tx_lane[SMP_W-1:0];
                end else begin
                    tx_item_o <= {SMP_W{1'b0}};
                end
            end
        end
    end


    // Receive formatter: four sign-extended items per payload, lowest lane first
    // Staging holds one finished word while the FIFO is busy
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pack_q <= {(`CFS_PAY_W-IW){1'b0}};
            word_q <= {`CFS_PAY_W{1'b0}};
            word_vld_q <= 1'b0;
            rx_overrun_o <= 1'b0;
        end else begin
            if (rx_take && !rx_word) begin
                pack_q[lane_q*IW +: IW] <= sext16(rx_item_i);
            end
            if (rx_word && (!word_vld_q || fifo_push_rx)) begin
                word_q <= {sext16(rx_item_i), pack_q};
                word_vld_q <= 1'b1;
            end else if (fifo_push_rx) begin
                word_vld_q <= 1'b0;
            end
            // A full FIFO drops the new word rather than stalling a free-running channel
            if (state_q == ST_INIT) begin
                rx_overrun_o <= 1'b0;
            end else if (rx_word && word_vld_q && !fifo_push_rx) begin
                rx_overrun_o <= 1'b1;
            end
        end
    end
endmodule // cfs_sync
`default_nettype wire

// ---- verilog/cfs_map.vh ----
`ifndef CFS_MAP_VH
`define CFS_MAP_VH
// Synchronizer states, one-hot
`define CFS_ST_IDLE 7'h01
`define CFS_ST_INIT 7'h02
`define CFS_ST_PRIME 7'h04
`define CFS_ST_START 7'h08
`define CFS_ST_STOP 7'h10
`define CFS_ST_PURGE 7'h20
`define CFS_ST_RESID 7'h40
// Start selections
`define CFS_START_NONE 2'h0
`define CFS_START_SW 2'h1
`define CFS_START_HW 2'h2
// Stop selections
`define CFS_STOP_OFF 2'h0
`define CFS_STOP_SW 2'h1
`define CFS_STOP_HW 2'h2
`define CFS_STOP_CNT 2'h3
// Payload and item layout
`define CFS_PAY_W 64
`define CFS_ITEM_W 16
`define CFS_LAST_LANE 2'h3
// Timing
`define CFS_CLK_PERIOD_NS 5
`define CFS_INIT_TIME_NS 100
`define CFS_INIT_CYC ((`CFS_INIT_TIME_NS + `CFS_CLK_PERIOD_NS - 1) / `CFS_CLK_PERIOD_NS)
`define CFS_PURGE_CYC 16
`define CFS_TMR_W 8
`endif

// ---- verilog/cfs_fifo.v ----
`default_nettype none
// Small FIFO with a registered output stage
module cfs_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_i,
    input wire resetn_i,
    input wire flush_i,
    input wire accept_en_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output reg in_ready_o,
    output reg [WIDTH-1:0] out_data_o,
    output reg out_valid_o,
    input wire out_ready_i,
    output reg empty_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    reg [AW:0] cnt_d;
    wire push = in_valid_i & in_ready_o;
    wire load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

    always @* begin
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end

    always @(posedge clk_i) begin
        if (push) begin
            mem[wp_q] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
            empty_o <= 1'b1;
        end else if (flush_i) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
            empty_o <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            if (push) begin
                wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (load) begin
                out_data_o <= mem[rp_q];
                out_valid_o <= 1'b1;
                rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
            // Registered ready: one slot of slack is never needed since cnt_d is exact
            in_ready_o <= accept_en_i & (cnt_d < DEPTH[AW:0]);
            empty_o <= (cnt_d == {(AW+1){1'b0}}) & ~(load | (out_valid_o & ~out_ready_i));
        end
    end
endmodule // cfs_fifo
`default_nettype wire

// ---- verilog/cfs_dummy_unused.v ----
`default_nettype none
`default_nettype wire

// ---- dv/cfs_sync_asserts.sv ----
`include "cfs_map.vh"
`default_nettype none
module cfs_sync_asserts #(
    parameter IS_TX = 0,
    parameter SMP_W = 12
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic dma_busy_i,
    input wire logic dma_arm_o,
    input wire logic [6:0] state_o,
    input wire logic proc_o,
    input wire logic tx_strobe_i,
    input wire logic [SMP_W-1:0] tx_item_o,
    input wire logic tx_item_valid_o,
    input wire logic [63:0] rx_wr_data_o,
    input wire logic rx_wr_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT_CYC = `CFS_INIT_CYC;
    logic [7:0] init_cnt_q;
    // Counts cycles already spent in initialize, so the dwell can be checked exactly
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            init_cnt_q <= 8'h00;
        end else begin
            init_cnt_q <= (state_o == `CFS_ST_INIT) ? init_cnt_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    a_idle_quiet: assert property (state_o == `CFS_ST_IDLE |-> !dma_arm_o && !proc_o)
        else $error("armed or processing while idle");
    a_idle_hold: assert property (state_o == `CFS_ST_IDLE && !enable_i |=> state_o == `CFS_ST_IDLE)
        else $error("idle left without enable");
    a_init_max: assert property (state_o == `CFS_ST_INIT |-> init_cnt_q < INIT_CYC)
        else $error("initialize too long");
    a_init_min: assert property (state_o == `CFS_ST_INIT && enable_i && init_cnt_q < INIT_CYC - 1
        |=> state_o == `CFS_ST_INIT) else $error("initialize too short");
    a_dir_skip: assert property (state_o != (IS_TX ? `CFS_ST_PURGE : `CFS_ST_PRIME))
        else $error("state not allowed for this direction");
    a_arm_states: assert property (dma_arm_o |-> (IS_TX ?
        state_o inside {`CFS_ST_PRIME, `CFS_ST_START, `CFS_ST_STOP} :
        state_o inside {`CFS_ST_START, `CFS_ST_STOP, `CFS_ST_PURGE, `CFS_ST_RESID}))
        else $error("armed in wrong state");
    a_rx_drain: assert property (IS_TX == 0 && state_o == `CFS_ST_RESID |-> dma_arm_o)
        else $error("receive residue not armed");
    a_resid_busy: assert property (state_o == `CFS_ST_RESID && dma_busy_i |=> state_o == `CFS_ST_RESID)
        else $error("residue left during burst");
    a_item_lat: assert property (IS_TX != 0 && tx_strobe_i |=> tx_item_valid_o)
        else $error("item not answered");
    a_gate_zero: assert property (tx_item_valid_o && $past(state_o) inside
        {`CFS_ST_IDLE, `CFS_ST_PRIME} |-> tx_item_o == '0) else $error("closed gate sent data");
    a_stop_exit: assert property ($past(state_o) == `CFS_ST_STOP && state_o != `CFS_ST_STOP
        |-> state_o == (IS_TX ? `CFS_ST_RESID : `CFS_ST_PURGE)) else $error("bad stop exit");
    a_abort: assert property (state_o == `CFS_ST_START && !enable_i |=> state_o == `CFS_ST_RESID)
        else $error("start wait not aborted");
    a_rx_sign: assert property (rx_wr_valid_o |-> &rx_wr_data_o[15:SMP_W-1]
        || !(|rx_wr_data_o[15:SMP_W-1])) else $error("lane not sign extended");
    c_prime: cover property (state_o == `CFS_ST_PRIME);
    c_purge: cover property (state_o == `CFS_ST_PURGE);
    c_abort: cover property (state_o == `CFS_ST_START && !enable_i ##1 state_o == `CFS_ST_RESID);
endmodule // cfs_sync_asserts
bind cfs_sync cfs_sync_asserts #(.IS_TX(IS_TX), .SMP_W(SMP_W)) cfs_sync_asserts_i (
    .mclk_i, .resetn_i, .enable_i, .dma_busy_i, .dma_arm_o, .state_o, .proc_o,
    .tx_strobe_i, .tx_item_o, .tx_item_valid_o, .rx_wr_data_o, .rx_wr_valid_o);
`default_nettype wire

// ---- dv/cfs_dma_model.sv ----
`default_nettype none
module cfs_dma_model (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic arm_i,
    input wire logic rd_ready_i,
    input wire logic wr_valid_i,
    input wire logic [63:0] wr_data_i,
    output logic busy_o,
    output logic [63:0] rd_data_o,
    output logic rd_valid_o,
    output logic wr_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] burst_q;
    logic [9:0] seq_q;
    logic [63:0] pay;
    logic [63:0] words_q [$];
    assign pay = {4'ha, seq_q, 2'h3, 4'ha, seq_q, 2'h2, 4'ha, seq_q, 2'h1, 4'ha, seq_q, 2'h0};
    assign busy_o = (burst_q != 3'h0);
    assign rd_valid_o = busy_o;
    // Released bus shows the inverse so a stale word cannot pass for fresh data
    assign rd_data_o = rd_valid_o ? pay : ~pay;
    // One stalled beat per burst, plus a gap between bursts, to exercise backpressure
    assign wr_ready_o = busy_o && (burst_q != 3'h3);
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            burst_q <= 3'h0;
            seq_q <= 10'h000;
        end else begin
            if (burst_q != 3'h0) begin
                burst_q <= burst_q - 3'h1;
            end else if (arm_i) begin
                burst_q <= 3'h5;
            end
            if (rd_valid_o && rd_ready_i) begin
                seq_q <= seq_q + 10'h001;
            end
            if (wr_valid_i && wr_ready_o) begin
                words_q.push_back(wr_data_i);
            end
        end
    end
endmodule // cfs_dma_model
`default_nettype wire

// ---- dv/cfs_sync_tb.sv ----
`include "cfs_map.vh"
`default_nettype none
module cfs_sync_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic enable_i = 1'h0;
    logic [1:0] start_sel_i = 2'h0;
    logic [1:0] stop_sel_i = 2'h0;
    logic [31:0] sample_count_i = 32'h5;
    logic sw_trig_i = 1'h0;
    logic hw_trig_i = 1'h0;
    logic tx_strobe_i = 1'h0;
    logic rx_strobe_i = 1'h0;
    logic [11:0] rx_item_i = 12'h000;
    wire [1:0] arm, idl, prc, ovr, busy, rdv, rdr, wrv, wrr, iv;
    wire [6:0] st [2];
    wire [63:0] rdd [2];
    wire [63:0] wrd [2];
    wire [11:0] item [2];
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    // Index 0 is the receive channel, index 1 the transmit channel
    for (genvar g = 0; g < 2; g++) begin : u
        cfs_sync #(.IS_TX(g)) cfs_sync_i (.mclk_i, .resetn_i, .enable_i, .start_sel_i,
            .stop_sel_i, .sample_count_i, .sw_trig_i, .hw_trig_i, .dma_busy_i(busy[g]),
            .dma_arm_o(arm[g]), .state_o(st[g]), .idle_o(idl[g]), .proc_o(prc[g]),
            .rx_overrun_o(ovr[g]), .tx_rd_data_i(rdd[g]), .tx_rd_valid_i(rdv[g]),
            .tx_rd_ready_o(rdr[g]), .tx_strobe_i, .tx_item_o(item[g]), .tx_item_valid_o(iv[g]),
            .rx_strobe_i, .rx_item_i, .rx_wr_data_o(wrd[g]), .rx_wr_valid_o(wrv[g]),
            .rx_wr_ready_i(wrr[g]));
        cfs_dma_model cfs_dma_model_i (.mclk_i, .resetn_i, .arm_i(arm[g]), .rd_ready_i(rdr[g]),
            .wr_valid_i(wrv[g]), .wr_data_i(wrd[g]), .busy_o(busy[g]), .rd_data_o(rdd[g]),
            .rd_valid_o(rdv[g]), .wr_ready_o(wrr[g]));
    end
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_st(input int c, input logic [6:0] s);
        int n;
        n = 0;
        while (st[c] !== s && n < 600) begin
            @(posedge mclk_i);
            n++;
        end
        chk(st[c], s, "state");
    endtask
    task automatic leave(input int c, input logic [6:0] s, input logic [6:0] exp);
        int n;
        n = 0;
        while (st[c] === s && n < 600) begin
            @(posedge mclk_i);
            n++;
        end
        chk(st[c], exp, "next state");
    endtask
    task automatic off();
        @(posedge mclk_i);
        enable_i <= 1'h0;
    endtask
    task automatic trig(input logic [1:0] sel, input int hold);
        @(posedge mclk_i);
        sw_trig_i <= (sel == 2'h1);
        hw_trig_i <= (sel == 2'h2);
        repeat (hold) @(posedge mclk_i);
        sw_trig_i <= 1'h0;
        hw_trig_i <= 1'h0;
    endtask
    // One item to both channels; the transmit answer is read two edges later
    task automatic strobe(input int n, input logic [11:0] exp);
        @(posedge mclk_i);
        tx_strobe_i <= 1'h1;
        rx_strobe_i <= 1'h1;
        rx_item_i <= 12'h800 | n[11:0];
        @(posedge mclk_i);
        tx_strobe_i <= 1'h0;
        rx_strobe_i <= 1'h0;
        @(posedge mclk_i);
        chk(iv[1], 1'h1, "item valid");
        chk(item[1], exp, "item");
    endtask
    task automatic run(input logic [1:0] s0, input logic [1:0] s1, input bit abort);
        int n;
        @(posedge mclk_i);
        start_sel_i <= s0;
        stop_sel_i <= s1;
        enable_i <= 1'h1;
        wait_st(0, `CFS_ST_INIT);
        n = 0;
        while (st[0] === `CFS_ST_INIT && n < 100) begin
            @(posedge mclk_i);
            n++;
        end
        chk(n, `CFS_INIT_CYC, "init cycles");
        chk(st[0], `CFS_ST_START, "rx after init");
        chk(st[1], `CFS_ST_PRIME, "tx after init");
        chk(arm, 2'h3, "armed");
        wait_st(1, `CFS_ST_START);
        if (s0 != 2'h0) begin
            repeat (8) @(posedge mclk_i);
            chk(st[0], `CFS_ST_START, "waiting");
        end
        if (abort) begin
            off();
            leave(0, `CFS_ST_START, `CFS_ST_RESID);
            leave(1, `CFS_ST_START, `CFS_ST_RESID);
        end else begin
            trig(s0, 6);
            wait_st(0, `CFS_ST_STOP);
            wait_st(1, `CFS_ST_STOP);
            repeat (6) @(posedge mclk_i);
            chk(st[0], `CFS_ST_STOP, "held trigger");
            chk(prc[0], 1'h1, "processing");
            if (s1 == 2'h0) begin
                off();
            end else if (s1 == 2'h3) begin
                for (int k = 0; k < 6; k++) begin
                    strobe(k, (k < 5) ? k[11:0] : 12'h000);
                    if (k == 3) begin
                        chk(st[0], `CFS_ST_STOP, "count not reached");
                    end
                end
            end else begin
                trig(s1, 2);
            end
            leave(0, `CFS_ST_STOP, `CFS_ST_PURGE);
            off();
            wait_st(0, `CFS_ST_RESID);
            chk(arm[0], 1'h1, "rx residue armed");
        end
        wait_st(0, `CFS_ST_IDLE);
        wait_st(1, `CFS_ST_IDLE);
        chk(idl, 2'h3, "idle flags");
        chk(ovr[0], 1'h0, "overrun");
        $display("run start %0d stop %0d abort %0d done", s0, s1, abort);
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("unexpected at %0t: timeout", $time);
            results();
        end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        resetn_i <= 1'h1;
        chk(st[0], `CFS_ST_IDLE, "reset state");
        chk(arm, 2'h0, "reset arm");
        run(2'h0, 2'h3, 1'b0);
        chk(u[0].cfs_dma_model_i.words_q.size(), 1, "word count");
        chk(u[0].cfs_dma_model_i.words_q[0], 64'hf803f802f801f800, "word");
        run(2'h1, 2'h1, 1'b0);
        run(2'h2, 2'h2, 1'b0);
        run(2'h2, 2'h0, 1'b0);
        run(2'h1, 2'h0, 1'b1);
        strobe(1, 12'h000);
        chk(wrv[0], 1'h0, "idle write");
        chk(u[0].cfs_dma_model_i.words_q.size(), 1, "idle words");
        $display("idle test done");
        results();
    end
endmodule // cfs_sync_tb
`default_nettype wire
